// ### design/i2cmr_consts.svh
// Constants for the two-wire master receive port: counts, widths, resets.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef I2CMR_CONSTS_SVH
`define I2CMR_CONSTS_SVH

`define I2CMR_BAUD_W      8
`define I2CMR_BYTE_W      8
`define I2CMR_CNT_W       4
`define I2CMR_STEP_W      2
`define I2CMR_LAST_BIT    4'h7
`define I2CMR_ACK_BIT     4'h8
`define I2CMR_STEP_0      2'h0
`define I2CMR_STEP_1      2'h1
`define I2CMR_STEP_2      2'h2
`define I2CMR_BYTE_RST    8'h00
`define I2CMR_CNT_RST     4'h0
`define I2CMR_BAUD_RST    8'h00

`endif

// ### design/i2cmr_pkg.sv
// Types shared by the two-wire master receive port and its helpers.
// Assumes i2cmr_consts.svh is on the include path.
`include "i2cmr_consts.svh"

package i2cmr_pkg;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_START = 6'h02,
    ST_ADDR  = 6'h04,
    ST_RECV  = 6'h08,
    ST_ACK   = 6'h10,
    ST_STOP  = 6'h20
  } i2cmr_state_t;

  // Software command strobes, one cycle each
  typedef struct packed {
    logic start_request_bit;
    logic stop_req;
    logic receive_enable_bit;
    logic ack_sequence_enable;
    logic ack_value_bit;
  } i2cmr_cmd_t;

  // Status seen by software
  typedef struct packed {
    logic port_event_flag;
    logic receive_overflow_flag;
    logic write_collision_flag;
    logic ack_received_status;
    logic receive_enable_bit;
    logic busy;
  } i2cmr_stat_t;

endpackage

// ### design/i2cmr_baud.sv
// Baud rate generator: a reload down-counter giving one-cycle ticks.
// Assumes run is held low while the port idles, which restarts the count.
`timescale 1ns/1ps
`include "i2cmr_consts.svh"

module i2cmr_baud (
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  input  wire logic                      clk_en,
  input  wire logic                      run,
  input  wire logic [`I2CMR_BAUD_W-1:0]  reload,
  output logic                           tick
);

  logic [`I2CMR_BAUD_W-1:0] cnt_ff;
  logic [`I2CMR_BAUD_W-1:0] nxt_cnt;
  logic                     tick_ff;
  logic                     nxt_tick;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (!run) begin
      nxt_cnt = reload;
    end else if (cnt_ff == `I2CMR_BAUD_RST) begin
      nxt_cnt  = reload;
      nxt_tick = 1'b1;
    end else begin
      nxt_cnt = cnt_ff - `I2CMR_BAUD_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_ff  <= `I2CMR_BAUD_RST;
      tick_ff <= 1'b0;
    end else if (clk_en) begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule

// ### design/i2cmr_buf2.sv
// Two-entry buffer with valid/ready on both sides; head is a register.
// Assumes the filler honours in_ready; out side may stall indefinitely.
`timescale 1ns/1ps
`include "i2cmr_consts.svh"

module i2cmr_buf2 (
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  input  wire logic                      clk_en,
  input  wire logic                      in_valid,
  output logic                           in_ready,
  input  wire logic [`I2CMR_BYTE_W-1:0]  in_data,
  output logic                           out_valid,
  input  wire logic                      out_ready,
  output logic [`I2CMR_BYTE_W-1:0]       out_data
);

  logic [`I2CMR_BYTE_W-1:0] head_ff, tail_ff, nxt_head, nxt_tail;
  logic                     hv_ff, tv_ff, nxt_hv, nxt_tv;
  logic                     pop, push;

  always_comb begin
    pop      = hv_ff && out_ready;
    push     = in_valid && !tv_ff;
    nxt_head = head_ff;
    nxt_tail = tail_ff;
    nxt_hv   = hv_ff;
    nxt_tv   = tv_ff;
    if (pop) begin
      nxt_head = tail_ff;
      nxt_hv   = tv_ff;
      nxt_tv   = 1'b0;
    end
    if (push) begin
      if (!nxt_hv) begin
        nxt_head = in_data;
        nxt_hv   = 1'b1;
      end else begin
        nxt_tail = in_data;
        nxt_tv   = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      head_ff <= `I2CMR_BYTE_RST;
      tail_ff <= `I2CMR_BYTE_RST;
      hv_ff   <= 1'b0;
      tv_ff   <= 1'b0;
    end else if (clk_en) begin
      head_ff <= nxt_head;
      tail_ff <= nxt_tail;
      hv_ff   <= nxt_hv;
      tv_ff   <= nxt_tv;
    end
  end

  // Ready drops only when both entries hold data
  assign in_ready  = !tv_ff;
  assign out_valid = hv_ff;
  assign out_data  = head_ff;

endmodule

// ### design/i2cmr_top.sv
// Two-wire bus master: start, stop, repeated start, address out, byte in,
// acknowledge out, with buffer and flag handling toward software.
// Assumes external pull-ups; pins come in unsynchronised, one clock domain.
//
// How it works
// - Start: SDA falls while SCL stays high.
// - Stop: SDA rises while SCL stays high.
// - Address and data bytes travel most significant bit first.
// - Direction bit after seven address bits: one reads, zero writes.
// - Acknowledge is SDA held low during the acknowledge clock.
// - SDA changes only while SCL low; changes with SCL high frame.
// - Both lines open drain; driven means zero, released means one.
// - Receiving master ends with stop instead of last acknowledge.
// - Master may repeat start instead of stop or final acknowledge.
// - Receive enable is ignored unless the port is idle.
// - Baud rollovers step SCL or SDA, waiting while SCL is held low; SDA shifted in on clock pulses.
// - Eighth falling edge: clear enable, load buffer, flag, hold SCL low.
// - Buffer full sets on load, clears when software reads the last buffered byte.
// - Overflow sets when a byte completes while buffer still full.
// - Buffer write while shifting sets collision, buffer unchanged.
// - Start request makes start condition; event flag on completion.
// - Writing the address byte starts shifting it out at once.
// - Slave acknowledge sampled to status; event at end of ninth clock.
// - Acknowledge sequence drives the acknowledge value for one clock.
// - Event flag set once the master acknowledge is clocked out.
`timescale 1ns/1ps
`include "i2cmr_consts.svh"

module i2cmr_top (
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  input  wire logic                      clk_en,
  input  wire logic                      scl_in,
  output logic                           scl_out,
  output logic                           scl_oe,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  input  wire logic [`I2CMR_BAUD_W-1:0]  baud_reload,
  input  wire i2cmr_pkg::i2cmr_cmd_t     cmd,
  input  wire logic                      buf_wr,
  input  wire logic [`I2CMR_BYTE_W-1:0]  buf_wdata,
  input  wire logic                      buf_rd,
  input  wire logic                      event_clr,
  input  wire logic                      overflow_clr,
  input  wire logic                      collision_clr,
  output i2cmr_pkg::i2cmr_stat_t         stat,
  output logic                           buffer_full_flag,
  output logic [`I2CMR_BYTE_W-1:0]       port_data_buffer
);

  i2cmr_pkg::i2cmr_state_t           state_ff, nxt_state;
  i2cmr_pkg::i2cmr_stat_t            stat_ff, nxt_stat;
  logic [`I2CMR_STEP_W-1:0]          step_ff, nxt_step;
  logic [`I2CMR_CNT_W-1:0]           bit_cnt_ff, nxt_bit_cnt;
  logic [`I2CMR_BYTE_W-1:0]          receive_shift_register_ff, nxt_receive_shift_register;
  logic [`I2CMR_BYTE_W-1:0]          rx_byte_ff, nxt_rx_byte;
  logic                              push_ff, nxt_push;
  logic                              scl_drv_ff, nxt_scl_drv;
  logic                              sda_drv_ff, nxt_sda_drv;
  logic                              scl_meta_ff, scl_s_ff;
  logic                              sda_meta_ff, sda_s_ff;
  logic                              tick;
  logic                              rx_ready;
  logic                              rx_valid;

  // Pins are asynchronous to clk_sys
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      scl_meta_ff <= 1'b1;
      scl_s_ff    <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_s_ff    <= 1'b1;
    end else if (clk_en) begin
      scl_meta_ff <= scl_in;
      scl_s_ff    <= scl_meta_ff;
      sda_meta_ff <= sda_in;
      sda_s_ff    <= sda_meta_ff;
    end
  end

  // Generator only runs outside idle, so SCL stays parked there
  i2cmr_baud u_baud (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .run     (state_ff != i2cmr_pkg::ST_IDLE),
    .reload  (baud_reload),
    .tick    (tick)
  );

  i2cmr_buf2 u_buf (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_valid  (push_ff),
    .in_ready  (rx_ready),
    .in_data   (rx_byte_ff),
    .out_valid (rx_valid),
    .out_ready (buf_rd),
    .out_data  (port_data_buffer)
  );

  always_comb begin
    nxt_state                  = state_ff;
    nxt_step                   = step_ff;
    nxt_bit_cnt                = bit_cnt_ff;
    nxt_receive_shift_register = receive_shift_register_ff;
    nxt_rx_byte                = rx_byte_ff;
    nxt_push                   = 1'b0;
    nxt_scl_drv                = scl_drv_ff;
    nxt_sda_drv                = sda_drv_ff;
    nxt_stat                   = stat_ff;
    // Clears first so a same-cycle set below wins
    if (event_clr) begin
      nxt_stat.port_event_flag = 1'b0;
    end
    if (overflow_clr) begin
      nxt_stat.receive_overflow_flag = 1'b0;
    end
    if (collision_clr) begin
      nxt_stat.write_collision_flag = 1'b0;
    end
    if (buf_wr && state_ff != i2cmr_pkg::ST_IDLE) begin
      nxt_stat.write_collision_flag = 1'b1;
    end
    case (state_ff)
      i2cmr_pkg::ST_IDLE: begin
        if (cmd.start_request_bit) begin
          nxt_state = i2cmr_pkg::ST_START;
          nxt_step  = `I2CMR_STEP_0;
        end else if (cmd.stop_req) begin
          nxt_state = i2cmr_pkg::ST_STOP;
          nxt_step  = `I2CMR_STEP_0;
        end else if (buf_wr) begin
          // Byte carries its direction bit in bit 0
          nxt_receive_shift_register = buf_wdata;
          nxt_bit_cnt                = `I2CMR_CNT_RST;
          nxt_step                   = `I2CMR_STEP_0;
          nxt_state                  = i2cmr_pkg::ST_ADDR;
        end else if (cmd.receive_enable_bit && rx_ready) begin
          // Refused while buffer cannot take another byte
          nxt_stat.receive_enable_bit = 1'b1;
          nxt_bit_cnt                 = `I2CMR_CNT_RST;
          nxt_step                    = `I2CMR_STEP_0;
          nxt_state                   = i2cmr_pkg::ST_RECV;
        end else if (cmd.ack_sequence_enable) begin
          nxt_receive_shift_register = {cmd.ack_value_bit, 7'h7F};
          nxt_bit_cnt                = `I2CMR_ACK_BIT;
          nxt_step                   = `I2CMR_STEP_0;
          nxt_state                  = i2cmr_pkg::ST_ACK;
        end
      end
      i2cmr_pkg::ST_START: begin
        case (step_ff)
          `I2CMR_STEP_0: begin
            nxt_sda_drv = 1'b0;
            if (tick) begin
              nxt_scl_drv = 1'b0;
              nxt_step    = `I2CMR_STEP_1;
            end
          end
          `I2CMR_STEP_1: begin
            // Wait for SCL really high before framing
            if (tick && scl_s_ff) begin
              nxt_sda_drv = 1'b1;
              nxt_step    = `I2CMR_STEP_2;
            end
          end
          default: begin
            if (tick) begin
              nxt_scl_drv              = 1'b1;
              nxt_stat.port_event_flag = 1'b1;
              nxt_state                = i2cmr_pkg::ST_IDLE;
            end
          end
        endcase
      end
      i2cmr_pkg::ST_STOP: begin
        case (step_ff)
          `I2CMR_STEP_0: begin
            nxt_sda_drv = 1'b1;
            if (tick) begin
              nxt_scl_drv = 1'b0;
              nxt_step    = `I2CMR_STEP_1;
            end
          end
          `I2CMR_STEP_1: begin
            if (tick && scl_s_ff) begin
              nxt_step = `I2CMR_STEP_2;
            end
          end
          default: begin
            if (tick) begin
              nxt_sda_drv              = 1'b0;
              nxt_stat.port_event_flag = 1'b1;
              nxt_stat.busy            = 1'b0;
              nxt_state                = i2cmr_pkg::ST_IDLE;
            end
          end
        endcase
      end
      i2cmr_pkg::ST_ADDR, i2cmr_pkg::ST_ACK: begin
        if (step_ff == `I2CMR_STEP_0) begin
          // Data only moves while SCL is low
          nxt_sda_drv = !receive_shift_register_ff[7];
          if (tick) begin
            nxt_scl_drv = 1'b0;
            nxt_step    = `I2CMR_STEP_1;
          end
        end else if (tick && scl_s_ff) begin
          nxt_scl_drv = 1'b1;
          nxt_step    = `I2CMR_STEP_0;
          if (bit_cnt_ff == `I2CMR_ACK_BIT) begin
            if (state_ff == i2cmr_pkg::ST_ADDR) begin
              nxt_stat.ack_received_status = sda_s_ff;
            end
            nxt_stat.port_event_flag = 1'b1;
            nxt_state                = i2cmr_pkg::ST_IDLE;
          end else begin
            // Shift in ones so SDA is released for the ninth clock
            nxt_receive_shift_register = {receive_shift_register_ff[6:0], 1'b1};
            nxt_bit_cnt                = bit_cnt_ff + `I2CMR_CNT_W'(1);
          end
        end
      end
      i2cmr_pkg::ST_RECV: begin
        nxt_sda_drv = 1'b0;
        if (step_ff == `I2CMR_STEP_0) begin
          if (tick) begin
            nxt_scl_drv = 1'b0;
            nxt_step    = `I2CMR_STEP_1;
          end
        end else if (tick && scl_s_ff) begin
          nxt_receive_shift_register = {receive_shift_register_ff[6:0], sda_s_ff};
          nxt_scl_drv                = 1'b1;
          nxt_step                   = `I2CMR_STEP_0;
          if (bit_cnt_ff == `I2CMR_LAST_BIT) begin
            nxt_rx_byte                 = {receive_shift_register_ff[6:0], sda_s_ff};
            nxt_push                    = 1'b1;
            nxt_stat.receive_enable_bit = 1'b0;
            nxt_stat.port_event_flag    = 1'b1;
            nxt_state                   = i2cmr_pkg::ST_IDLE;
            if (rx_valid && !buf_rd) begin
              nxt_stat.receive_overflow_flag = 1'b1;
            end
          end else begin
            nxt_bit_cnt = bit_cnt_ff + `I2CMR_CNT_W'(1);
          end
        end
      end
      default: begin
        nxt_state   = i2cmr_pkg::ST_IDLE;
        nxt_scl_drv = 1'b0;
        nxt_sda_drv = 1'b0;
      end
    endcase
    if (nxt_state == i2cmr_pkg::ST_START) begin
      nxt_stat.busy = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_ff                  <= i2cmr_pkg::ST_IDLE;
      step_ff                   <= `I2CMR_STEP_0;
      bit_cnt_ff                <= `I2CMR_CNT_RST;
      receive_shift_register_ff <= `I2CMR_BYTE_RST;
      rx_byte_ff                <= `I2CMR_BYTE_RST;
      push_ff                   <= 1'b0;
      scl_drv_ff                <= 1'b0;
      sda_drv_ff                <= 1'b0;
      stat_ff                   <= '0;
    end else if (clk_en) begin
      state_ff                  <= nxt_state;
      step_ff                   <= nxt_step;
      bit_cnt_ff                <= nxt_bit_cnt;
      receive_shift_register_ff <= nxt_receive_shift_register;
      rx_byte_ff                <= nxt_rx_byte;
      push_ff                   <= nxt_push;
      scl_drv_ff                <= nxt_scl_drv;
      sda_drv_ff                <= nxt_sda_drv;
      stat_ff                   <= nxt_stat;
    end
  end

  // Open drain: only ever drive zero
  assign scl_out          = 1'b0;
  assign sda_out          = 1'b0;
  assign scl_oe           = scl_drv_ff;
  assign sda_oe           = sda_drv_ff;
  assign stat             = stat_ff;
  assign buffer_full_flag = rx_valid;

endmodule

// ### tb/i2cmr_top_properties.sv
// Concurrent checks on the master receive port's pins and flags.
// Assumes binding to i2cmr_top; one clock domain, synchronous reset.
`timescale 1ns/1ps
`include "i2cmr_consts.svh"

module i2cmr_chk (
  input wire logic                        clk_sys,
  input wire logic                        sys_rst,
  input wire logic                        scl_in,
  input wire logic                        scl_oe,
  input wire logic                        sda_oe,
  input wire logic [`I2CMR_BAUD_W-1:0]    baud_reload,
  input wire i2cmr_pkg::i2cmr_cmd_t       cmd,
  input wire logic                        buf_wr,
  input wire logic                        buf_rd,
  input wire logic                        event_clr,
  input wire i2cmr_pkg::i2cmr_stat_t      stat,
  input wire logic                        buffer_full_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_start_frame: assert property ($rose(sda_oe) && !scl_oe |-> scl_in)
    else $error("sda pulled while scl was low");
  a_stop_frame: assert property ($fell(sda_oe) && !scl_oe |-> scl_in)
    else $error("sda released while scl was low");
  // Half period is reload+1 cycles, so no toggle may follow within two
  a_scl_pace: assert property ($changed(scl_oe) && baud_reload > 8'h01 |=> $stable(scl_oe) [*2])
    else $error("scl toggled faster than the baud period");
  a_rcv_release: assert property (stat.receive_enable_bit && !scl_oe |-> !sda_oe)
    else $error("master drove sda during a receive clock");
  a_rcv_done: assert property ($fell(stat.receive_enable_bit) |->
    (scl_oe && stat.port_event_flag) ##[0:3] buffer_full_flag)
    else $error("receive end without scl hold, event or load");
  a_full_clear: assert property ($fell(buffer_full_flag) |-> $past(buf_rd))
    else $error("buffer full cleared without a read");
  a_ovf_cause: assert property ($rose(stat.receive_overflow_flag) |-> $past(buffer_full_flag))
    else $error("overflow without a full buffer");
  a_write_collision_flag_cause: assert property ($rose(stat.write_collision_flag) |-> $past(buf_wr))
    else $error("collision without a buffer write");
  a_event_hold: assert property (stat.port_event_flag && !event_clr |=> stat.port_event_flag)
    else $error("event flag dropped without a clear");
  a_start_event: assert property (cmd.start_request_bit && !stat.busy |->
    ##[1:1000] (stat.busy && stat.port_event_flag))
    else $error("start request never completed");

  c_start: cover property ($rose(stat.busy));
  c_stop: cover property ($fell(stat.busy));
  c_ovf: cover property ($rose(stat.receive_overflow_flag));
  c_write_collision_flag: cover property ($rose(stat.write_collision_flag));
endmodule

bind i2cmr_top i2cmr_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl_in),
  .scl_oe(scl_oe), .sda_oe(sda_oe), .baud_reload(baud_reload), .cmd(cmd), .buf_wr(buf_wr),
  .buf_rd(buf_rd), .event_clr(event_clr), .stat(stat), .buffer_full_flag(buffer_full_flag));

// ### tb/i2cmr_slave.sv
// Behavioural two-wire slave answering reads with a counting byte.
// Assumes open-drain wires resolved by the bench; pull-ups give idle high.
`timescale 1ns/1ps

module i2cmr_slave #(
  parameter logic [6:0] ADDR  = 7'h2A,
  parameter logic [7:0] DATA0 = 8'h1D
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       stretch,
  output logic            scl_oe,
  output logic            sda_oe,
  output logic [7:0]      got_addr,
  output logic            got_ack,
  output logic            stop_seen
);
  logic       rs;
  logic [7:0] nbyte;

  task automatic xfer();
    logic [7:0] a;
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) begin
      @(posedge scl);
      a[i] = sda;
    end
    got_addr = a;
    @(negedge scl);
    if (a[7:1] != ADDR) return;
    // Off the clock edge, so the pin synchroniser never races this drive
    #30 sda_oe = 1'b1;
    @(negedge scl);
    if (!a[0]) return;
    forever begin
      d = DATA0 + nbyte;
      for (int i = 7; i >= 0; i--) begin
        // Grab scl first so a slow answer never moves sda while high
        if (stretch) scl_oe = 1'b1;
        #30 sda_oe = ~d[i];
        if (stretch) #300 scl_oe = 1'b0;
        @(negedge scl);
      end
      nbyte++;
      #30 sda_oe = 1'b0;
      @(posedge scl);
      got_ack = ~sda;
      if (sda) return;
      @(negedge scl);
    end
  endtask

  always @(posedge sda) begin
    if (scl === 1'b1) stop_seen = 1'b1;
  end

  initial begin
    {scl_oe, sda_oe, got_ack, stop_seen, rs} = 5'h00;
    got_addr = 8'h00;
    nbyte = 8'h00;
    forever begin
      if (!rs) @(negedge sda iff scl === 1'b1);
      rs = 1'b0;
      stop_seen = 1'b0;
      fork
        xfer();
        @(posedge sda iff scl === 1'b1);
        begin
          @(negedge sda iff scl === 1'b1);
          rs = 1'b1;
        end
      join_any
      disable fork;
      {scl_oe, sda_oe} = 2'h0;
    end
  end
endmodule

// ### tb/i2cmr_top_tb.sv
// Self-checking bench: start, address, receive, acknowledge, stop flows.
// Assumes the slave model and bound checker are compiled alongside.
`timescale 1ns/1ps
`include "i2cmr_consts.svh"

module i2cmr_top_tb;
  localparam logic [6:0] SL_ADDR = 7'h2A;
  localparam logic [7:0] DATA0   = 8'h1D;
  localparam logic [4:0] C_START = 5'h10;
  localparam logic [4:0] C_STOP  = 5'h08;
  localparam logic [4:0] C_RCV   = 5'h04;
  localparam logic [4:0] C_ACK0  = 5'h02;
  localparam logic [4:0] C_ACK1  = 5'h03;

  logic                   clk_sys = 1'b0;
  logic                   sys_rst = 1'b1;
  logic                   scl_oe, sda_oe, sl_scl_oe, sl_sda_oe, scl_out, sda_out;
  logic                   buf_wr, buf_rd, event_clr, overflow_clr, collision_clr;
  logic                   stretch, got_ack, stop_seen, buffer_full_flag;
  logic [7:0]             buf_wdata, port_data_buffer, got_addr;
  i2cmr_pkg::i2cmr_cmd_t  cmd;
  i2cmr_pkg::i2cmr_stat_t stat;
  int                     err_count, total_checks;
  wire                    scl_w = ~(scl_oe | sl_scl_oe);
  wire                    sda_w = ~(sda_oe | sl_sda_oe);

  always #12.5 clk_sys = ~clk_sys;

  i2cmr_top u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .baud_reload(8'h02), .cmd(cmd), .buf_wr(buf_wr), .buf_wdata(buf_wdata), .buf_rd(buf_rd),
    .event_clr(event_clr), .overflow_clr(overflow_clr), .collision_clr(collision_clr),
    .stat(stat), .buffer_full_flag(buffer_full_flag), .port_data_buffer(port_data_buffer));

  i2cmr_slave #(.ADDR(SL_ADDR), .DATA0(DATA0)) u_slave (.scl(scl_w), .sda(sda_w),
    .stretch(stretch), .scl_oe(sl_scl_oe), .sda_oe(sl_sda_oe), .got_addr(got_addr),
    .got_ack(got_ack), .stop_seen(stop_seen));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic step();
    @(posedge clk_sys);
    #2;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic op(input logic [4:0] c);
    step();
    cmd = c;
    step();
    cmd = 5'h00;
  endtask

  task automatic wait_evt();
    int n;
    n = 0;
    while (stat.port_event_flag !== 1'b1 && n < 5000) begin
      step();
      n++;
    end
    if (n >= 5000) begin
      err_count++;
      $display("wrong value at %0t ns: event never came", $time);
      tally_and_finish();
    end
    // Buffer load lands one cycle after the push
    repeat (3) step();
  endtask

  task automatic run(input logic [4:0] c);
    op(c);
    wait_evt();
  endtask

  task automatic clr_evt();
    step();
    event_clr = 1'b1;
    step();
    event_clr = 1'b0;
  endtask

  task automatic wr(input logic [7:0] b);
    step();
    buf_wdata = b;
    buf_wr = 1'b1;
    step();
    buf_wr = 1'b0;
  endtask

  task automatic pop();
    step();
    buf_rd = 1'b1;
    step();
    buf_rd = 1'b0;
    step();
  endtask

  initial begin
    {buf_wr, buf_rd, event_clr, overflow_clr, collision_clr, stretch} = 6'h00;
    cmd = 5'h00;
    buf_wdata = 8'h00;
    err_count = 0;
    total_checks = 0;
    repeat (20) @(posedge clk_sys);
    #2 sys_rst = 1'b0;
    chk({stat, buffer_full_flag, scl_oe}, 8'h00, "reset state");
    chk({scl_out, sda_out}, 8'h00, "open drain data low");
    run(C_START);
    chk(stat.busy, 1'b1, "busy after start");
    clr_evt();
    wr({SL_ADDR, 1'b1});
    wait_evt();
    chk(stat.ack_received_status, 1'b0, "address ack");
    chk(got_addr, {SL_ADDR, 1'b1}, "address on wire");
    clr_evt();
    op(C_RCV);
    chk(stat.receive_enable_bit, 1'b1, "receive enable set");
    repeat (10) step();
    wr(8'hFF);
    step();
    chk(stat.write_collision_flag, 1'b1, "collision");
    wait_evt();
    chk({buffer_full_flag, stat.receive_enable_bit, scl_oe}, 8'h05, "receive end");
    chk(port_data_buffer, DATA0, "first byte");
    repeat (40) step();
    chk(stat.port_event_flag, 1'b1, "event persists");
    clr_evt();
    pop();
    chk(buffer_full_flag, 1'b0, "full after read");
    run(C_ACK0);
    chk(got_ack, 1'b1, "master ack seen");
    clr_evt();
    $display("test single byte done");

    stretch = 1'b1;
    run(C_RCV);
    chk(port_data_buffer, DATA0 + 8'h01, "stretched byte");
    clr_evt();
    op(C_ACK0);
    op(C_RCV);
    wait_evt();
    chk(stat.receive_enable_bit, 1'b0, "busy receive ignored");
    clr_evt();
    run(C_RCV);
    chk({stat.receive_overflow_flag, buffer_full_flag}, 8'h03, "overflow");
    clr_evt();
    run(C_ACK1);
    chk(got_ack, 1'b0, "master nack seen");
    clr_evt();
    chk(port_data_buffer, DATA0 + 8'h01, "head kept");
    pop();
    chk(port_data_buffer, DATA0 + 8'h02, "second kept");
    pop();
    chk(buffer_full_flag, 1'b0, "drained");
    step();
    {overflow_clr, collision_clr} = 2'h3;
    step();
    {overflow_clr, collision_clr} = 2'h0;
    step();
    chk({stat.receive_overflow_flag, stat.write_collision_flag}, 8'h00, "flag clear");
    stretch = 1'b0;
    $display("test overflow done");

    run(C_START);
    chk(stat.busy, 1'b1, "repeated start");
    clr_evt();
    wr({7'h11, 1'b1});
    wait_evt();
    chk(stat.ack_received_status, 1'b1, "absent slave");
    chk(got_addr, {7'h11, 1'b1}, "address after restart");
    clr_evt();
    run(C_START);
    clr_evt();
    wr({SL_ADDR, 1'b1});
    wait_evt();
    clr_evt();
    run(C_RCV);
    chk(port_data_buffer, DATA0 + 8'h03, "byte after restart");
    clr_evt();
    pop();
    run(C_STOP);
    chk({stat.busy, stop_seen, scl_w, sda_w}, 8'h07, "stop ends");
    clr_evt();
    $display("test restart and stop done");
    tally_and_finish();
  end
endmodule
